/* src/card_check_pkg.sv */
package card_check_pkg;
  localparam int ADDR_W = 18;
  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_CHECK_HIGH  = 16'hfe14;
  localparam logic [15:0] IDX_CHECK_LOW   = 16'hfe15;
  localparam logic [15:0] IDX_BLOCK_GUARD = 16'hfe16;
  localparam logic [15:0] IDX_EXTRA_GUARD = 16'hfe17;
  localparam logic [15:0] IDX_WAIT_B3     = 16'hfe18;
  localparam logic [15:0] IDX_WAIT_B2     = 16'hfe19;
  localparam logic [15:0] IDX_WAIT_B1     = 16'hfe1a;
  localparam logic [15:0] IDX_WAIT_B0     = 16'hfe1b;
  localparam logic [15:0] IDX_CONTROL     = 16'hfe30;
  localparam logic [15:0] IDX_STATUS      = 16'hfe31;
  localparam logic [15:0] IDX_RATIO       = 16'hfe32;
  localparam logic [7:0]  RST_CHECK_BYTE  = 8'hff;
  localparam logic [7:0]  RST_BLOCK_GUARD = 8'h10;
  localparam logic [7:0]  RST_EXTRA_GUARD = 8'h0c;
  localparam logic [7:0]  RST_WAIT_BYTE   = 8'h00;
  localparam logic [7:0]  RST_CONTROL     = 8'h00;
  localparam logic [12:0] RST_RATIO       = 13'h0174;
  localparam int EXTRA_TOP_POS = 7;
  localparam int BLOCK_MSB_POS = 4;
  localparam int CTRL_T1_POS   = 0;
  localparam int CTRL_GEN_POS  = 1;
  localparam int CTRL_LRC_POS  = 2;
  localparam int STAT_TO_POS   = 0;
  localparam int STAT_OK_POS   = 1;
  localparam int STAT_APP_POS  = 2;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE  = 16'h1d0f;
  localparam logic [8:0]  MIN_GAP_T0   = 9'h00c;
  localparam logic [8:0]  MIN_GAP_T1   = 9'h00b;
  localparam int WAIT_W = 28;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction
endpackage

/* src/etu_divider.sv */
`timescale 1ns/10ps
module etu_divider import card_check_pkg::*; #(
  parameter int RATIO_W = 13
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               card_clk_tick,
  input  wire logic [RATIO_W-1:0] ratio,
  output logic                    etu_tick
);
  logic [RATIO_W:0] count;
  logic [RATIO_W:0] limit;

  // one etu is twice the ratio in intermediate clock ticks; ratio 0 acts as 1
  always_comb begin
    limit = (ratio == '0) ? (RATIO_W+1)'(1) : {ratio, 1'b0} - (RATIO_W+1)'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count    <= '0;
      etu_tick <= 1'b0;
    end else begin
      etu_tick <= 1'b0;
      if (card_clk_tick) begin
        if (count >= limit) begin
          count    <= '0;
          etu_tick <= 1'b1;
        end else begin
          count <= count + (RATIO_W+1)'(1);
        end
      end
    end
  end
endmodule

/* src/card_check_guard.sv */
`timescale 1ns/10ps
module card_check_guard import card_check_pkg::*; #(
  parameter int RATIO_W = 13
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              intermediate_card_clock,
  input  wire logic              tx_data_valid,
  input  wire logic [7:0]        tx_data,
  input  wire logic              tx_data_last,
  output logic                   tx_data_ready,
  output logic                   ser_valid,
  output logic [7:0]             ser_data,
  input  wire logic              ser_ready,
  input  wire logic              rx_start_edge,
  input  wire logic              rx_char_valid,
  input  wire logic [7:0]        rx_char_data,
  output logic                   rx_fifo_valid,
  output logic [7:0]             rx_fifo_data,
  input  wire logic              card_break,
  output logic                   wait_timeout
);
  typedef enum logic [1:0] {tx_data_phase, tx_crc_high, tx_check_tail} tx_state_type;

  logic [7:0]         check_word_high;
  logic [7:0]         check_word_low;
  logic [7:0]         block_guard_time;
  logic [7:0]         extra_guard_low_byte;
  logic [7:0]         wait_limit_byte3;
  logic [7:0]         wait_limit_byte2;
  logic [7:0]         wait_limit_byte1;
  logic [7:0]         wait_limit_byte0;
  logic [7:0]         control;
  logic [RATIO_W-1:0] ratio;
  logic               timeout_flag;
  tx_state_type       tx_state;
  logic               hold_valid;
  logic               hold_last;
  logic [7:0]         send_low;
  logic [9:0]         gap_cnt;
  logic [5:0]         bgt_cnt;
  logic               last_was_rx;
  logic [WAIT_W-1:0]  wait_cnt;
  logic               wait_run;
  logic               etu_tick;
  logic               t1_mode;
  logic               check_generate_enable;
  logic               lrc_mode;
  logic [8:0]         extra_guard_time;
  logic [8:0]         eff_gap;
  logic [4:0]         block_guard;
  logic [WAIT_W-1:0]  wait_limit;
  logic               tx_fire;
  logic               gap_ok;
  logic               block_ok;
  logic               break_hold;
  logic               do_append;
  logic [15:0]        check_word;
  logic [15:0]        next_check;
  logic [7:0]         upd_byte;
  logic               upd_en;
  logic               wr_en;
  logic               rd_setup;
  logic               wait_expire;
  logic               check_ok;

  // bit-serial CRC, msb first, folded over one byte
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    crc_byte = c;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == byte_addr(idx));
  endfunction

  assign t1_mode               = control[CTRL_T1_POS];
  assign check_generate_enable = control[CTRL_GEN_POS];
  assign lrc_mode              = control[CTRL_LRC_POS];
  assign extra_guard_time      = {block_guard_time[EXTRA_TOP_POS], extra_guard_low_byte};
  assign block_guard           = block_guard_time[BLOCK_MSB_POS:0];
  assign wait_limit            = {wait_limit_byte3[3:0], wait_limit_byte2,
                                  wait_limit_byte1, wait_limit_byte0};
  assign check_word            = {check_word_high, check_word_low};
  assign check_ok              = lrc_mode ? (check_word_low == 8'h00)
                                          : (check_word == CRC_RESIDUE);

  etu_divider #(.RATIO_W(RATIO_W)) u_etu (
    .pclk          (pclk),
    .presetn       (presetn),
    .card_clk_tick (intermediate_card_clock),
    .ratio         (ratio),
    .etu_tick      (etu_tick)
  );

  // apb slave: zero wait states, error on unmapped index
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = ~(hit(paddr, IDX_CHECK_HIGH) | hit(paddr, IDX_CHECK_LOW) |
                  hit(paddr, IDX_BLOCK_GUARD) | hit(paddr, IDX_EXTRA_GUARD) |
                  hit(paddr, IDX_WAIT_B3) | hit(paddr, IDX_WAIT_B2) |
                  hit(paddr, IDX_WAIT_B1) | hit(paddr, IDX_WAIT_B0) |
                  hit(paddr, IDX_CONTROL) | hit(paddr, IDX_STATUS) |
                  hit(paddr, IDX_RATIO));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= '0;
      if (hit(paddr, IDX_CHECK_HIGH))  prdata[7:0] <= check_word_high;
      if (hit(paddr, IDX_CHECK_LOW))   prdata[7:0] <= check_word_low;
      if (hit(paddr, IDX_BLOCK_GUARD)) prdata[7:0] <= block_guard_time;
      if (hit(paddr, IDX_EXTRA_GUARD)) prdata[7:0] <= extra_guard_low_byte;
      if (hit(paddr, IDX_WAIT_B3))     prdata[7:0] <= wait_limit_byte3;
      if (hit(paddr, IDX_WAIT_B2))     prdata[7:0] <= wait_limit_byte2;
      if (hit(paddr, IDX_WAIT_B1))     prdata[7:0] <= wait_limit_byte1;
      if (hit(paddr, IDX_WAIT_B0))     prdata[7:0] <= wait_limit_byte0;
      if (hit(paddr, IDX_CONTROL))     prdata[7:0] <= control;
      if (hit(paddr, IDX_RATIO))       prdata[RATIO_W-1:0] <= ratio;
      if (hit(paddr, IDX_STATUS)) begin
        prdata[STAT_TO_POS]  <= timeout_flag;
        prdata[STAT_OK_POS]  <= check_ok;
        prdata[STAT_APP_POS] <= (tx_state != tx_data_phase);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_guard_time     <= RST_BLOCK_GUARD;
      extra_guard_low_byte <= RST_EXTRA_GUARD;
      wait_limit_byte3     <= RST_WAIT_BYTE;
      wait_limit_byte2     <= RST_WAIT_BYTE;
      wait_limit_byte1     <= RST_WAIT_BYTE;
      wait_limit_byte0     <= RST_WAIT_BYTE;
      control              <= RST_CONTROL;
      ratio                <= RST_RATIO;
    end else if (wr_en) begin
      // bits 6:5 of the block guard register are reserved and read zero
      if (hit(paddr, IDX_BLOCK_GUARD)) block_guard_time <= pwdata[7:0] & 8'h9f;
      if (hit(paddr, IDX_EXTRA_GUARD)) extra_guard_low_byte <= pwdata[7:0];
      if (hit(paddr, IDX_WAIT_B3))     wait_limit_byte3 <= pwdata[7:0] & 8'h0f;
      if (hit(paddr, IDX_WAIT_B2))     wait_limit_byte2 <= pwdata[7:0];
      if (hit(paddr, IDX_WAIT_B1))     wait_limit_byte1 <= pwdata[7:0];
      if (hit(paddr, IDX_WAIT_B0))     wait_limit_byte0 <= pwdata[7:0];
      if (hit(paddr, IDX_CONTROL))     control <= pwdata[7:0] & 8'h07;
      if (hit(paddr, IDX_RATIO))       ratio <= pwdata[RATIO_W-1:0];
    end
  end

  // check register: the framing engine hands direct-convention bytes both ways
  assign upd_en   = rx_char_valid | tx_fire;
  assign upd_byte = rx_char_valid ? rx_char_data : ser_data;

  always_comb begin
    next_check = check_word;
    if (lrc_mode) begin
      next_check[7:0] = check_word_low ^ upd_byte;
    end else begin
      next_check = crc_byte(check_word, upd_byte);
    end
  end

  // a firmware reload wins over a same-cycle update so a new message starts clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_word_high <= RST_CHECK_BYTE;
      check_word_low  <= RST_CHECK_BYTE;
    end else begin
      if (upd_en) begin
        check_word_high <= next_check[15:8];
        check_word_low  <= next_check[7:0];
      end
      if (wr_en && hit(paddr, IDX_CHECK_HIGH)) check_word_high <= pwdata[7:0];
      if (wr_en && hit(paddr, IDX_CHECK_LOW))  check_word_low  <= pwdata[7:0];
    end
  end

  // transmit path: one holding byte, then the appended check bytes
  assign eff_gap    = (extra_guard_time > (t1_mode ? MIN_GAP_T1 : MIN_GAP_T0)) ?
                      extra_guard_time : (t1_mode ? MIN_GAP_T1 : MIN_GAP_T0);
  assign gap_ok     = (gap_cnt > {1'b0, eff_gap}); // strict, first etu is partial
  assign block_ok   = ~last_was_rx | (bgt_cnt > {1'b0, block_guard});
  assign break_hold = ~t1_mode & card_break;
  assign ser_valid  = hold_valid & gap_ok & block_ok & ~break_hold;
  assign tx_fire    = ser_valid & ser_ready;
  assign tx_data_ready = (tx_state == tx_data_phase) & ~hold_valid;
  assign do_append  = hold_last & check_generate_enable & t1_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state   <= tx_data_phase;
      hold_valid <= 1'b0;
      hold_last  <= 1'b0;
      ser_data   <= 8'h00;
      send_low   <= 8'h00;
    end else begin
      case (tx_state)
        tx_data_phase: begin
          if (tx_fire && do_append) begin
            send_low  <= next_check[7:0];
            ser_data  <= lrc_mode ? next_check[7:0] : next_check[15:8];
            hold_last <= 1'b0;
            tx_state  <= lrc_mode ? tx_check_tail : tx_crc_high;
          end else if (tx_fire) begin
            hold_valid <= 1'b0;
          end else if (tx_data_valid && tx_data_ready) begin
            hold_valid <= 1'b1;
            ser_data   <= tx_data;
            hold_last  <= tx_data_last;
          end
        end
        tx_crc_high: begin
          if (tx_fire) begin
            ser_data <= send_low;
            tx_state <= tx_check_tail;
          end
        end
        tx_check_tail: begin
          if (tx_fire) begin
            hold_valid <= 1'b0;
            tx_state   <= tx_data_phase;
          end
        end
        default: begin
          tx_state   <= tx_data_phase;
          hold_valid <= 1'b0;
        end
      endcase
    end
  end

  // guard counters restart at start edges and count etus, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt     <= '1;
      bgt_cnt     <= '1;
      last_was_rx <= 1'b0;
    end else begin
      if (tx_fire) begin
        gap_cnt <= '0;
      end else if (etu_tick && gap_cnt != '1) begin
        gap_cnt <= gap_cnt + 10'h001;
      end
      if (rx_start_edge) begin
        bgt_cnt <= '0;
      end else if (etu_tick && bgt_cnt != '1) begin
        bgt_cnt <= bgt_cnt + 6'h01;
      end
      if (rx_start_edge) begin
        last_was_rx <= 1'b1;
      end else if (tx_fire) begin
        last_was_rx <= 1'b0;
      end
    end
  end

  // wait timer; stops after one expiry so the flag is raised once per gap
  assign wait_expire = etu_tick & wait_run & (wait_cnt == wait_limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= '0;
      wait_run <= 1'b0;
    end else begin
      if (tx_fire || (rx_start_edge && !t1_mode)) begin
        wait_cnt <= '0;
        wait_run <= 1'b1;
      end else if (rx_start_edge) begin
        wait_run <= 1'b0;
      end else if (wait_expire) begin
        wait_run <= 1'b0;
      end else if (etu_tick && wait_run) begin
        wait_cnt <= wait_cnt + 28'h0000001;
      end
    end
  end

  // sticky timeout; write one to clear, a new expiry wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= 1'b0;
    end else if (wait_expire) begin
      timeout_flag <= 1'b1;
    end else if (wr_en && hit(paddr, IDX_STATUS) && pwdata[STAT_TO_POS]) begin
      timeout_flag <= 1'b0;
    end
  end
  assign wait_timeout = timeout_flag;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fifo_valid <= 1'b0;
      rx_fifo_data  <= 8'h00;
    end else begin
      rx_fifo_valid <= rx_char_valid;
      if (rx_char_valid) rx_fifo_data <= rx_char_data;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence crc_append_start;
    tx_fire && do_append && !lrc_mode && tx_state == tx_data_phase;
  endsequence
  sequence crc_high_out;
    tx_state == tx_crc_high && ser_data == $past(next_check[15:8]);
  endsequence

  guard_spacing_a: assert property (tx_fire |-> gap_cnt > eff_gap)
    else $error("start bits closer than extra guard time");
  min_spacing_a: assert property (tx_fire |-> gap_cnt > (t1_mode ? MIN_GAP_T1 : MIN_GAP_T0))
    else $error("character spacing below mode minimum");
  break_hold_a: assert property (!t1_mode && card_break |-> !ser_valid)
    else $error("start bit issued during card break");
  block_guard_a: assert property (tx_fire && last_was_rx |-> bgt_cnt > block_guard)
    else $error("first transmit before block guard time");
  crc_append_a: assert property (crc_append_start |=> crc_high_out)
    else $error("check word high byte not appended");
  wait_expire_a: assert property (wait_expire |=> wait_timeout && !wait_run)
    else $error("wait timer expiry not flagged");
  gap_restart_a: assert property (tx_fire ##1 !tx_fire |-> gap_cnt <= 9'd1)
    else $error("guard counter did not restart");
  rx_fifo_a: assert property (rx_char_valid |=> rx_fifo_valid &&
                              rx_fifo_data == $past(rx_char_data))
    else $error("received byte not passed to fifo");
endmodule

/* verif/card_model.sv */
`timescale 1ns/10ps
module card_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic       ser_valid,
  input  wire logic [7:0] ser_data,
  output logic            ser_ready,
  output logic            rx_start_edge,
  output logic            rx_char_valid,
  output logic [7:0]      rx_char_data,
  output logic            card_break
);
  logic [7:0] sent_q[$];
  int         sent_t[$];
  int         cyc = 0;
  int         rx_start_t = 0;

  initial begin
    ser_ready = 1'b0;
    rx_start_edge = 1'b0;
    rx_char_valid = 1'b0;
    rx_char_data = 8'h00;
    card_break = 1'b0;
  end

  // a slow card accepts a start bit only on alternate cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ser_ready <= presetn & (slow ? ~ser_ready : 1'b1);
    if (ser_valid === 1'b1 && ser_ready === 1'b1) begin
      sent_q.push_back(ser_data);
      sent_t.push_back(cyc);
    end
  end

  // one received character: start edge, then the decoded byte a frame later
  task automatic reply(input logic [7:0] b);
    @(posedge pclk);
    rx_start_edge <= 1'b1;
    rx_start_t <= cyc;
    @(posedge pclk);
    rx_start_edge <= 1'b0;
    repeat (18) @(posedge pclk);
    rx_char_valid <= 1'b1;
    rx_char_data <= b;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char_data <= ~b; // released line never keeps the last byte
  endtask

  task automatic set_break(input logic v);
    @(posedge pclk);
    card_break <= v;
  endtask
endmodule

/* verif/card_check_guard_tb_top.sv */
`timescale 1ns/10ps
module card_check_guard_tb_top import card_check_pkg::*;;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready, pslverr, ser_valid, ser_ready, tx_data_ready;
  logic              icc = 1'b0;
  logic              tx_data_valid = 1'b0;
  logic [7:0]        tx_data = 8'h00;
  logic              tx_data_last = 1'b0;
  logic [7:0]        ser_data, rx_char_data, rx_fifo_data;
  logic              rx_start_edge, rx_char_valid, rx_fifo_valid, card_break, wait_timeout;
  logic              slow = 1'b0;
  logic [7:0]        fifo_q[$];
  int                error_cnt = 0;
  int                n_tests = 0;
  int                cyc = 0;

  always #2.5 pclk = ~pclk;

  card_check_guard card_check_guard_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .intermediate_card_clock(icc),
    .tx_data_valid(tx_data_valid), .tx_data(tx_data), .tx_data_last(tx_data_last),
    .tx_data_ready(tx_data_ready), .ser_valid(ser_valid), .ser_data(ser_data),
    .ser_ready(ser_ready), .rx_start_edge(rx_start_edge), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_fifo_valid(rx_fifo_valid), .rx_fifo_data(rx_fifo_data),
    .card_break(card_break), .wait_timeout(wait_timeout));

  card_model card_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
    .ser_valid(ser_valid), .ser_data(ser_data), .ser_ready(ser_ready),
    .rx_start_edge(rx_start_edge), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .card_break(card_break));

  // card clock tick every other cycle: with ratio 1 an ETU is 4 cycles
  always @(posedge pclk) begin
    icc <= ~icc;
    cyc <= cyc + 1;
    if (rx_fifo_valid === 1'b1) fifo_q.push_back(rx_fifo_data);
    if (cyc == 30000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input string nm);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(nm, r, exp);
  endtask

  task automatic send(input logic [7:0] b, input logic l);
    @(posedge pclk);
    tx_data_valid <= 1'b1;
    tx_data <= b;
    tx_data_last <= l;
    do begin
      @(posedge pclk);
    end while (tx_data_ready !== 1'b1);
    tx_data_valid <= 1'b0;
    tx_data <= ~b;
  endtask

  task automatic wait_sent(input int n);
    while (card_model_inst.sent_q.size() < n) begin
      @(posedge pclk);
    end
  endtask

  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    return c;
  endfunction

  initial begin
    logic [31:0] r;
    logic        e;
    logic [15:0] c;
    logic [7:0]  rxb[3];
    int          nb, g;
    rxb = '{8'ha5, 8'h5a, 8'h3c};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_BLOCK_GUARD, 32'h10, "block_guard_rst");
    rd(IDX_EXTRA_GUARD, 32'h0c, "extra_guard_rst");
    for (int i = 0; i < 4; i++) rd(IDX_WAIT_B3 + 16'(i), 32'h0, "wait_rst");
    rd(IDX_CHECK_HIGH, 32'hff, "check_high_rst");
    apb(1'b0, 16'hfe40, 32'h0, r, e);
    chk("unmapped_err", {31'h0, e}, 32'h1);
    wr(IDX_RATIO, 32'h1);
    wr(IDX_EXTRA_GUARD, 32'h0d);
    wr(IDX_BLOCK_GUARD, 32'h9f);
    rd(IDX_BLOCK_GUARD, 32'h9f, "block_guard_rw");
    wr(IDX_BLOCK_GUARD, 32'h10);
    wr(IDX_WAIT_B3, 32'hff);
    rd(IDX_WAIT_B3, 32'h0f, "wait_b3_width");
    wr(IDX_WAIT_B3, 32'h0);
    // crc generation in T=1, firmware presets all ones
    wr(IDX_CONTROL, 32'h3);
    wr(IDX_CHECK_HIGH, 32'hff);
    wr(IDX_CHECK_LOW, 32'hff);
    send(8'h12, 1'b0);
    send(8'h34, 1'b1);
    wait_sent(4);
    c = crc(crc(16'hffff, 8'h12), 8'h34);
    chk("crc_high_sent", card_model_inst.sent_q[2], c[15:8]);
    chk("crc_low_sent", card_model_inst.sent_q[3], c[7:0]);
    for (int i = 1; i < 4; i++) begin
      g = card_model_inst.sent_t[i] - card_model_inst.sent_t[i-1];
      chk("char_gap", 32'(g >= 52 && g <= 60), 32'h1);
    end
    c = crc(crc(c, c[15:8]), c[7:0]);
    rd(IDX_CHECK_HIGH, c[15:8], "tx_check_high");
    rd(IDX_CHECK_LOW, c[7:0], "tx_check_low");
    // receive with generation off: register still accumulates
    wr(IDX_CONTROL, 32'h1);
    wr(IDX_CHECK_HIGH, 32'hff);
    wr(IDX_CHECK_LOW, 32'hff);
    c = 16'hffff;
    foreach (rxb[i]) begin
      card_model_inst.reply(rxb[i]);
      c = crc(c, rxb[i]);
    end
    // the last byte reaches the fifo queue two edges after its pulse
    repeat (2) @(posedge pclk);
    foreach (rxb[i]) chk("rx_fifo", fifo_q[i], rxb[i]);
    rd(IDX_CHECK_HIGH, c[15:8], "rx_check_high");
    rd(IDX_CHECK_LOW, c[7:0], "rx_check_low");
    apb(1'b0, IDX_STATUS, 32'h0, r, e);
    chk("crc_ok", r[STAT_OK_POS], 32'(c == 16'h1d0f));
    // first transmit after reception waits the block guard of 16 ETU
    nb = card_model_inst.sent_q.size();
    send(8'h77, 1'b0);
    wait_sent(nb + 1);
    g = card_model_inst.sent_t[nb] - card_model_inst.rx_start_t;
    chk("block_guard_gap", 32'(g >= 64 && g <= 76), 32'h1);
    // lrc against a stalling card: one appended byte only
    wr(IDX_CONTROL, 32'h7);
    wr(IDX_CHECK_LOW, 32'h0);
    slow <= 1'b1;
    nb = card_model_inst.sent_q.size();
    send(8'h13, 1'b0);
    send(8'h25, 1'b1);
    wait_sent(nb + 3);
    repeat (100) @(posedge pclk);
    chk("lrc_count", card_model_inst.sent_q.size(), nb + 3);
    chk("lrc_byte", card_model_inst.sent_q[nb+2], 8'h36);
    slow <= 1'b0;
    rd(IDX_CHECK_LOW, 32'h0, "lrc_residue");
    apb(1'b0, IDX_STATUS, 32'h0, r, e);
    chk("lrc_ok", r[STAT_OK_POS], 32'h1);
    // silent card: block wait of 5 ETU runs out
    wr(IDX_CONTROL, 32'h1);
    wr(IDX_WAIT_B0, 32'h5);
    wr(IDX_STATUS, 32'h1);
    nb = card_model_inst.sent_q.size();
    send(8'h01, 1'b0);
    wait_sent(nb + 1);
    repeat (8) @(posedge pclk);
    chk("timeout_early", wait_timeout, 32'h0);
    repeat (40) @(posedge pclk);
    chk("timeout_set", wait_timeout, 32'h1);
    apb(1'b0, IDX_STATUS, 32'h0, r, e);
    chk("timeout_status", r[STAT_TO_POS], 32'h1);
    wr(IDX_STATUS, 32'h1);
    @(posedge pclk);
    chk("timeout_clear", wait_timeout, 32'h0);
    // answering card stops the timer
    wr(IDX_WAIT_B0, 32'd20);
    nb = card_model_inst.sent_q.size();
    send(8'h02, 1'b0);
    wait_sent(nb + 1);
    card_model_inst.reply(8'h55);
    repeat (120) @(posedge pclk);
    chk("timeout_answered", wait_timeout, 32'h0);
    // T=0 break holds the next start bit; extra guard below the T=0 floor
    wr(IDX_CONTROL, 32'h0);
    wr(IDX_EXTRA_GUARD, 32'h02);
    card_model_inst.set_break(1'b1);
    nb = card_model_inst.sent_q.size();
    send(8'h44, 1'b0);
    repeat (100) @(posedge pclk);
    chk("break_hold", card_model_inst.sent_q.size(), nb);
    card_model_inst.set_break(1'b0);
    wait_sent(nb + 1);
    chk("break_release", card_model_inst.sent_q[nb], 8'h44);
    send(8'h45, 1'b0);
    wait_sent(nb + 2);
    g = card_model_inst.sent_t[nb+1] - card_model_inst.sent_t[nb];
    chk("t0_min_gap", 32'(g >= 48 && g <= 56), 32'h1);
    // silent card in T=0: work wait of 20 ETU runs out after the last start bit
    repeat (60) @(posedge pclk);
    chk("work_wait_early", wait_timeout, 32'h0);
    repeat (40) @(posedge pclk);
    chk("work_wait_set", wait_timeout, 32'h1);
    summarize();
  end
endmodule
